// ==== rtl/vcc_common_ports.v ====
`timescale 1ns/100ps
`include "vcc_consts.vh"
module vcc_common_ports #(
  parameter HAS_REG_CTRL = 1,
  parameter HAS_INTC     = 1
) (
  // core clock domain
  input  wire                     clk,
  input  wire                     rst_n,
  input  wire                     coreEn,
  // upstream video stream
  input  wire [`VCC_DATA_W-1:0]   sTdata,
  input  wire                     sTvalid,
  input  wire                     sTuser,
  input  wire                     sTlast,
  output wire                     sTready,
  // downstream video stream
  output wire [`VCC_DATA_W-1:0]   mTdata,
  output wire                     mTvalid,
  output wire                     mTuser,
  output wire                     mTlast,
  input  wire                     mTready,
  // event bus to external interrupt controller
  output reg  [`VCC_EVT_W-1:0]    externalIrqControllerBus_reg,
  // reset held long enough
  output reg                      resetOk_reg,
  // control clock domain
  input  wire                     ctrlClk,
  input  wire                     ctrlRst_n,
  input  wire                     ctrlEn,
  input  wire                     irqAck,
  output reg                      irq_reg
);
  wire sReadyW;
  wire mValidW;
  wire mUserW;
  wire mLastW;
  wire [`VCC_DATA_W-1:0] mDataW;

  // every stream signal lives on clk
  vcc_stream_stage uStage (
    .clk        (clk),
    .rst_n      (rst_n),
    .coreEn     (coreEn),
    .sData      (sTdata),
    .sValid     (sTvalid),
    .sUser      (sTuser),
    .sLast      (sTlast),
    .sReady_reg (sReadyW),
    .mData_reg  (mDataW),
    .mValid_reg (mValidW),
    .mUser_reg  (mUserW),
    .mLast_reg  (mLastW),
    .mReady     (mTready)
  );
  assign sTready = sReadyW;
  assign mTdata  = mDataW;
  assign mTvalid = mValidW;
  assign mTuser  = mUserW;
  assign mTlast  = mLastW;

  // reset length watch
  reg  [`VCC_RST_CNT_W-1:0] rstCnt_reg;
  reg                       rstSeen_reg;
  always @(posedge clk) begin
    if (!rst_n) begin
      // first low edge loads one, so an unknown power-up count never sticks
      if (rstSeen_reg) begin
        if (rstCnt_reg != `VCC_RST_MIN_CYC) begin
          rstCnt_reg <= rstCnt_reg + {{(`VCC_RST_CNT_W-1){1'b0}}, 1'b1};
        end
      end else begin
        rstCnt_reg <= {{(`VCC_RST_CNT_W-1){1'b0}}, 1'b1};
      end
      rstSeen_reg <= 1'b1;
      resetOk_reg <= 1'b0;
    end else begin
      rstCnt_reg <= {`VCC_RST_CNT_W{1'b0}};
      if (rstSeen_reg) begin
        resetOk_reg <= (rstCnt_reg == `VCC_RST_MIN_CYC);
        rstSeen_reg <= 1'b0;
      end
    end
  end

  // stream events: user/last pulses on accepted beats, stall bits high on each blocked cycle
  wire inBeat  = sTvalid & sReadyW;
  wire outBeat = mValidW & mTready;
  wire [`VCC_EVT_W-1:0] evt = {mValidW & ~mTready, sTvalid & ~sReadyW,
                               outBeat & mLastW, outBeat & mUserW,
                               inBeat & sTlast, inBeat & sTuser};
  reg frameTgl_reg;
  always @(posedge clk) begin
    if (!rst_n) begin
      externalIrqControllerBus_reg <= {`VCC_EVT_W{1'b0}};
      frameTgl_reg                 <= 1'b0;
    end else if (coreEn) begin
      if (HAS_INTC != 0) begin
        externalIrqControllerBus_reg <= evt;
      end else begin
        externalIrqControllerBus_reg <= {`VCC_EVT_W{1'b0}};
      end
      if (evt[`VCC_EVT_SOF_OUT]) begin
        frameTgl_reg <= ~frameTgl_reg;
      end
    end
  end

  // control side: own clock, enable, reset
  reg frameSync1_reg;
  reg frameSync2_reg;
  reg frameSync3_reg;
  always @(posedge ctrlClk) begin
    if (!ctrlRst_n) begin
      frameSync1_reg <= 1'b0;
      frameSync2_reg <= 1'b0;
      frameSync3_reg <= 1'b0;
      irq_reg        <= 1'b0;
    end else if (ctrlEn) begin
      frameSync1_reg <= frameTgl_reg;
      frameSync2_reg <= frameSync1_reg;
      frameSync3_reg <= frameSync2_reg;
      if (HAS_REG_CTRL == 0) begin
        irq_reg <= 1'b0;
      end else if (frameSync2_reg ^ frameSync3_reg) begin
        irq_reg <= 1'b1;
      end else if (irqAck) begin
        irq_reg <= 1'b0;
      end
    end
  end
endmodule // vcc_common_ports

// ==== rtl/vcc_consts.vh ====
`ifndef VCC_CONSTS_VH
`define VCC_CONSTS_VH
`define VCC_DATA_W        24
`define VCC_EVT_W         6
`define VCC_RST_MIN_CYC   32
`define VCC_RST_CNT_W     6
`define VCC_EVT_SOF_IN    0
`define VCC_EVT_EOL_IN    1
`define VCC_EVT_SOF_OUT   2
`define VCC_EVT_EOL_OUT   3
`define VCC_EVT_STALL_IN  4
`define VCC_EVT_STALL_OUT 5
`endif

// ==== rtl/vcc_stream_stage.v ====
`timescale 1ns/100ps
`include "vcc_consts.vh"
module vcc_stream_stage (
  // core clock and control
  input  wire                     clk,
  input  wire                     rst_n,
  input  wire                     coreEn,
  // upstream
  input  wire [`VCC_DATA_W-1:0]   sData,
  input  wire                     sValid,
  input  wire                     sUser,
  input  wire                     sLast,
  output reg                      sReady_reg,
  // downstream
  output reg  [`VCC_DATA_W-1:0]   mData_reg,
  output reg                      mValid_reg,
  output reg                      mUser_reg,
  output reg                      mLast_reg,
  input  wire                     mReady
);
  reg [`VCC_DATA_W+1:0] skid_reg;
  reg                   skidValid_reg;
  wire                  accept  = sValid & sReady_reg;
  wire                  outMove = ~mValid_reg | mReady;
  wire [`VCC_DATA_W+1:0] inWord = {sUser, sLast, sData};

  always @(posedge clk) begin
    if (!rst_n) begin
      sReady_reg    <= 1'b0;
      mValid_reg    <= 1'b0;
      mData_reg     <= {`VCC_DATA_W{1'b0}};
      mUser_reg     <= 1'b0;
      mLast_reg     <= 1'b0;
      skid_reg      <= {(`VCC_DATA_W+2){1'b0}};
      skidValid_reg <= 1'b0;
    end else if (coreEn) begin
      // inputs sampled only here, outputs only updated here and in the reset branch above
      if (outMove) begin
        if (skidValid_reg) begin
          {mUser_reg, mLast_reg, mData_reg} <= skid_reg;
          mValid_reg    <= 1'b1;
          skidValid_reg <= 1'b0;
          sReady_reg    <= 1'b1;
        end else begin
          mValid_reg <= accept;
          if (accept) begin
            {mUser_reg, mLast_reg, mData_reg} <= inWord;
          end
          sReady_reg <= 1'b1;
        end
      end else if (accept) begin
        skid_reg      <= inWord;
        skidValid_reg <= 1'b1;
        sReady_reg    <= 1'b0;
      end else begin
        sReady_reg <= ~skidValid_reg;
      end
    end
  end
endmodule // vcc_stream_stage

// ==== tb/vcc_common_ports_test.sv ====
`timescale 1ns/100ps
`include "vcc_consts.vh"
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin errors++; \
  $display("wrong value %0t got %h exp %h", $time, a, b); end end
module vcc_common_ports_test;
  reg                    clk = 1'b0, ctrlClk = 1'b0, rst_n = 1'b0, ctrlRst_n = 1'b0;
  reg                    coreEn = 1'b1, sTvalid = 1'b0, sTuser = 1'b0, sTlast = 1'b0;
  reg                    irqAck = 1'b0, slow = 1'b0, ctrlEn = 1'b1;
  reg  [`VCC_DATA_W-1:0] sTdata = 24'h000000;
  wire [`VCC_DATA_W-1:0] mTdata;
  wire [`VCC_EVT_W-1:0]  ev;
  wire                   sTready, mTvalid, mTuser, mTlast, mTready, resetOk, irq;
  reg  [25:0]            q[$];
  reg  [25:0]            w;
  integer                errors = 0, samplesChecked = 0;
  always #2 clk = ~clk;
  always #5 ctrlClk = ~ctrlClk;
  vcc_common_ports dut_u (.clk, .rst_n, .coreEn, .sTdata, .sTvalid, .sTuser, .sTlast, .sTready,
    .mTdata, .mTvalid, .mTuser, .mTlast, .mTready, .externalIrqControllerBus_reg(ev),
    .resetOk_reg(resetOk), .ctrlClk, .ctrlRst_n, .ctrlEn, .irqAck, .irq_reg(irq));
  vcc_sink sink_u (.clk, .slow, .mTready_reg(mTready));
  always @(posedge clk) if (rst_n && coreEn && mTvalid && mTready) begin
    w = q.pop_front();
    `CHK({mTlast, mTuser, mTdata}, w)
  end
  task send(input [24:0] v, input lst);
    sTvalid <= 1'b1;
    {sTuser, sTdata} <= v;
    sTlast <= lst;
    q.push_back({lst, v});
    do @(posedge clk); while (!(sTready && coreEn));
  endtask
  task t_stream;
    int i;
    @(posedge clk);
    slow <= 1'b1;
    for (i = 0; i < 4; i++) send({i == 0, 24'hA50000 | 24'(i)}, i == 3);
    sTvalid <= 1'b0;
    repeat (24) @(posedge clk);
    `CHK(q.size(), 0)
    slow <= 1'b0;
  endtask
  task t_frame;
    reg [31:0] snap;
    @(posedge ctrlClk);
    `CHK(irq, 1'b1)
    ctrlEn <= 1'b0;
    irqAck <= 1'b1;
    repeat (2) @(posedge ctrlClk);
    #1 `CHK(irq, 1'b1)
    ctrlEn <= 1'b1;
    @(posedge ctrlClk);
    irqAck <= 1'b0;
    #1 `CHK(irq, 1'b0)
    @(posedge clk);
    send(25'h1ABCDEF, 1'b1);
    sTvalid <= 1'b0;
    coreEn <= 1'b0;
    #1 `CHK(ev, 6'h03)
    snap = {mTvalid, mTdata, sTready, ev};
    repeat (5) @(posedge clk);
    #1 `CHK({mTvalid, mTdata, sTready, ev}, snap)
    @(posedge clk);
    coreEn <= 1'b1;
    @(posedge clk);
    #1 `CHK(ev, 6'h0C)
    repeat (6) @(posedge ctrlClk);
    `CHK(irq, 1'b1)
    coreEn <= 1'b0;
    @(posedge ctrlClk);
    irqAck <= 1'b1;
    @(posedge ctrlClk);
    irqAck <= 1'b0;
    #1 `CHK(irq, 1'b0)
    coreEn <= 1'b1;
  endtask
  task t_longRst;
    @(posedge clk);
    coreEn <= 1'b0;
    rst_n <= 1'b0;
    repeat (32) @(posedge clk);
    #1 `CHK({sTready, mTvalid, resetOk}, 3'h0)
    @(posedge clk);
    rst_n <= 1'b1;
    coreEn <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK({sTready, resetOk}, 2'h3)
  endtask
  task results;
    $display("errors %0d checked %0d", errors, samplesChecked);
    if (errors == 0 && samplesChecked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    ctrlRst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK(resetOk, 1'b0)
    t_stream;
    t_frame;
    t_longRst;
    results;
  end
  initial begin
    #20000;
    errors++;
    results;
  end
endmodule // vcc_common_ports_test

// ==== tb/vcc_props.sv ====
`timescale 1ns/100ps
`include "vcc_consts.vh"
module vcc_props (
  input wire                   clk, rst_n, coreEn, sTvalid, sTuser, sTlast, sTready,
  input wire [`VCC_DATA_W-1:0] sTdata, mTdata,
  input wire                   mTvalid, mTuser, mTlast, mTready,
  input wire [`VCC_EVT_W-1:0]  externalIrqControllerBus_reg
);
  wire [5:0] ev     = externalIrqControllerBus_reg;
  wire       inBeat = coreEn & sTvalid & sTready;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  rst_clear_a: assert property ($rose(rst_n) |-> !mTvalid && !sTready && ev == 6'h00)
    else $error("reset left outputs set");
  ready_up_a: assert property ($rose(rst_n) && coreEn |=> sTready)
    else $error("ready not raised");
  freeze_hold_a: assert property (!coreEn |=> $stable({mTdata, mTvalid, mTuser, sTready, ev}))
    else $error("state moved while disabled");
  out_hold_a: assert property (mTvalid && !(mTready && coreEn) |=> mTvalid && $stable(mTdata))
    else $error("output beat dropped");
  beat_pass_a: assert property (inBeat && !mTvalid |=>
    mTvalid && {mTuser, mTdata} == $past({sTuser, sTdata})) else $error("beat not passed");
  sof_in_a: assert property (coreEn |=> ev[0] == $past(inBeat && sTuser))
    else $error("start event wrong");
  eol_in_a: assert property (coreEn |=> ev[1] == $past(inBeat && sTlast))
    else $error("line end event wrong");
  sof_out_a: assert property (coreEn |=> ev[2] == $past(mTvalid && mTready && mTuser))
    else $error("output start event wrong");
  eol_out_a: assert property (coreEn |=> ev[3] == $past(mTvalid && mTready && mTlast))
    else $error("output line end event wrong");
  stall_evt_a: assert property (coreEn |=>
    ev[5:4] == $past({mTvalid && !mTready, sTvalid && !sTready})) else $error("stall event wrong");
  cover property (inBeat && sTuser);
  cover property (ev[3]);
  cover property (!coreEn && mTvalid);
  cover property (ev[4]);
endmodule // vcc_props
bind vcc_common_ports vcc_props props_u (.clk, .rst_n, .coreEn, .sTvalid, .sTuser, .sTlast,
  .sTready, .sTdata, .mTdata, .mTvalid, .mTuser, .mTlast, .mTready, .externalIrqControllerBus_reg);

// ==== tb/vcc_sink.sv ====
`timescale 1ns/100ps
module vcc_sink (
  input  wire clk,
  input  wire slow,
  output reg  mTready_reg = 1'b0
);
  reg [1:0] cnt_reg = 2'h0;
  // ready one cycle in four when slow
  always @(posedge clk) begin
    cnt_reg <= cnt_reg + 2'h1;
    mTready_reg <= !slow || (cnt_reg == 2'h3);
  end
endmodule // vcc_sink
